/* File: hw/flash_program_control.v */
// Control and status logic of the program flash sequencer
//
// Notes on behaviour
// RULE_01 - A one written to start is taken only while op_arm is one and the unlock has just passed.
// RULE_02 - Start launches the selected operation, hardware clears it at the end, it reads zero when idle.
// RULE_03 - Device reset returns op_arm and start to their reset values; other control fields keep theirs.
// RULE_04 - op_arm one allows start writes and powers the low supply detector, zero blocks and stops both.
// RULE_05 - op_fail_flag is set when a program or erase does not finish well and stays zero otherwise.
// RULE_06 - With detection on, a low supply sets low_supply_error, a hint of corruption with op_fail_flag.
// RULE_07 - low_supply_status follows the detector and is set and cleared by hardware only.
// RULE_08 - op_select is written only while op_arm is zero; writes while it is one are dropped.
// RULE_09 - Code 0101 erases the whole array, only if no page is write-protected.
// RULE_10 - Code 0100 erases the addressed page, only if that page is not write-protected.
// RULE_11 - Code 0011 programs the addressed row, only if that row is not write-protected.
// RULE_12 - Codes 0110, 0010 and 0000 do no flash operation when started.
// RULE_13 - Software keeps away from the reserved codes 0111 to 1111.
// RULE_14 - Starting with code 0000 clears the error flags.
// RULE_15 - Bits 31 to 16 and 10 to 4 always read as zero.
// RULE_16 - A parameterised key match must pass just before a start write is taken.
`timescale 1ns/1ps
`include "flash_program_control_regs.vh"
module flash_program_control
#(
   parameter [31:0] KEY_FIRST  = 32'h1234_ABCD, // Arbitrary key value
   parameter [31:0] KEY_SECOND = 32'hCDEF_5678  // Arbitrary key value
)
(
   clk,
   rst,
   por,
   ce,
   addr,
   wdata,
   wr,
   rd,
   rdata_q,
   flash_done,
   flash_fail,
   protect_any,
   protect_target,
   low_supply_raw,
   flash_req_q,
   flash_cmd_q,
   detector_en_q,
   busy_q,
   irq_q
);
   input  wire        clk;
   input  wire        rst;
   input  wire        por;
   input  wire        ce;
   input  wire [7:0]  addr;
   input  wire [31:0] wdata;
   input  wire        wr;
   input  wire        rd;
   output reg  [31:0] rdata_q;
   input  wire        flash_done;
   input  wire        flash_fail;
   input  wire        protect_any;
   input  wire        protect_target;
   input  wire        low_supply_raw;
   output reg         flash_req_q;
   output reg  [1:0]  flash_cmd_q;
   output reg         detector_en_q;
   output reg         busy_q;
   output reg         irq_q;

   // Sequencer states
   localparam [1:0] ST_IDLE   = 2'b00;
   localparam [1:0] ST_LAUNCH = 2'b01;
   localparam [1:0] ST_WAIT   = 2'b10;
   localparam [1:0] ST_END    = 2'b11;

   // Does this code drive the flash array
   function is_flash_op;
      input [3:0] op;
      begin
         is_flash_op = (op == `OP_ROW_PROGRAM) || (op == `OP_PAGE_ERASE) ||
                       (op == `OP_FULL_ERASE);
      end
   endfunction

   reg  [1:0]  state_q;
   reg  [1:0]  state_d;
   reg         start_q;
   reg         arm_q;
   reg         fail_q;
   reg         ls_err_q;
   reg  [3:0]  op_q;
   reg  [2:0]  ev_q;
   reg  [2:0]  mask_q;
   reg         ls_meta_q;
   reg         ls_sync_q;
   reg         op_fail_d;
   reg         op_end_d;
   reg         req_d;
   wire        unlocked;
   wire        sel_ctrl;
   wire        sel_key;
   wire        sel_stat;
   wire        sel_mask;
   wire        start_take;
   wire        ls_stat;
   wire        protected_now;
   wire [2:0]  ev_set;
   wire [31:0] ctrl_word;

   // Address decode
   assign sel_ctrl = (addr == `CTRL_OFS);
   assign sel_key  = (addr == `KEY_OFS);
   assign sel_stat = (addr == `IRQ_STATUS_OFS);
   assign sel_mask = (addr == `IRQ_MASK_OFS);

   // Unlock key checker
   unlock_key_check
   #(
      .KEY_FIRST  (KEY_FIRST),
      .KEY_SECOND (KEY_SECOND)
   )
   u_key
   (
      .clk        (clk),
      .rst        (rst),
      .ce         (ce),
      .wr_stb     (wr),
      .key_sel    (sel_key),
      .wdata      (wdata),
      .unlocked_q (unlocked)
   );

   // Start is taken only when armed, unlocked and idle
   assign start_take = ce && wr && sel_ctrl && wdata[`START_BIT] && arm_q && unlocked &&
                       (state_q == ST_IDLE);                           // RULE_01 RULE_04 RULE_16

   // Detector status is live only while the detector is powered
   assign ls_stat = arm_q && ls_sync_q;                                // RULE_07 RULE_04

   // Write protection that blocks the selected operation
   assign protected_now = (op_q == `OP_FULL_ERASE) ? protect_any       // RULE_09
                                                   : protect_target;   // RULE_10 RULE_11

   // Control word as software sees it
   assign ctrl_word = {16'h0000, start_q, arm_q, fail_q, ls_err_q, ls_stat,
                       7'h00, op_q};                                   // RULE_15

   // Low supply detector input synchroniser
   always @(posedge clk)
   begin
      if (por)
      begin
         ls_meta_q <= 1'b0;
         ls_sync_q <= 1'b0;
      end
      else if (ce)
      begin
         ls_meta_q <= low_supply_raw;
         ls_sync_q <= ls_meta_q;
      end
   end

   // Sequencer next state and launch decisions
   always @*
   begin
      state_d   = state_q;
      op_fail_d = 1'b0;
      op_end_d  = 1'b0;
      req_d     = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            if (start_take)
               state_d = ST_LAUNCH;                                    // RULE_02
         end
         ST_LAUNCH:
         begin
            if (!is_flash_op(op_q))
            begin
               state_d = ST_END;                                       // RULE_12
            end
            else if (protected_now)
            begin
               op_fail_d = 1'b1;                                       // RULE_05
               state_d   = ST_END;
            end
            else
            begin
               req_d   = 1'b1;                                         // RULE_09 RULE_10 RULE_11
               state_d = ST_WAIT;
            end
         end
         ST_WAIT:
         begin
            if (flash_done)
            begin
               op_fail_d = flash_fail;                                 // RULE_05
               state_d   = ST_END;
            end
         end
         ST_END:
         begin
            op_end_d = 1'b1;
            state_d  = ST_IDLE;                                        // RULE_02
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Sequencer and flash array request
   always @(posedge clk)
   begin
      if (por || rst)
      begin
         state_q     <= ST_IDLE;
         start_q     <= 1'b0;
         flash_req_q <= 1'b0;
         flash_cmd_q <= 2'h0;
         busy_q      <= 1'b0;
      end
      else if (ce)
      begin
         state_q     <= state_d;
         flash_req_q <= req_d;
         if (req_d)
         begin
            case (op_q)
               `OP_FULL_ERASE:  flash_cmd_q <= `CMD_FULL_ERASE;        // RULE_09
               `OP_PAGE_ERASE:  flash_cmd_q <= `CMD_PAGE_ERASE;        // RULE_10
               default:         flash_cmd_q <= `CMD_ROW_PROGRAM;       // RULE_11
            endcase
         end
         if (start_take)
            start_q <= 1'b1;                                           // RULE_02
         else if (op_end_d)
            start_q <= 1'b0;                                           // RULE_02
         busy_q <= (state_d != ST_IDLE);
      end
   end

   // Arm bit, which device reset clears along with start in the sequencer block
   always @(posedge clk)
   begin
      if (por || rst)
      begin
         arm_q         <= 1'b0;                                        // RULE_03
         detector_en_q <= 1'b0;
      end
      else if (ce)
      begin
         if (wr && sel_ctrl)
            arm_q <= wdata[`ARM_BIT];
         detector_en_q <= (wr && sel_ctrl) ? wdata[`ARM_BIT] : arm_q;  // RULE_04
      end
   end

   // Fields that survive device reset and are reset only at power-on
   always @(posedge clk)
   begin
      if (por)
      begin
         op_q     <= `OP_RESET;
         fail_q   <= 1'b0;
         ls_err_q <= 1'b0;
      end
      else if (ce)
      begin
         if (wr && sel_ctrl && !arm_q)
            op_q <= wdata[`OP_MSB:`OP_LSB];                            // RULE_08
         if (op_fail_d)
            fail_q <= 1'b1;                                            // RULE_05
         else if (op_end_d && op_q == `OP_NONE)
            fail_q <= 1'b0;                                            // RULE_14
         if (ls_stat)
            ls_err_q <= 1'b1;                                          // RULE_06
         else if (op_end_d && op_q == `OP_NONE)
            ls_err_q <= 1'b0;                                          // RULE_14
      end
   end

   // Interrupt events: done, fail, low supply error rising
   assign ev_set = {ls_stat && !ls_err_q, op_fail_d, op_end_d};

   // Sticky status with write-one-to-clear, set wins
   always @(posedge clk)
   begin
      if (por || rst)
      begin
         ev_q   <= 3'h0;
         mask_q <= `IRQ_MASK_RESET;
         irq_q  <= 1'b0;
      end
      else if (ce)
      begin
         if (wr && sel_stat)
            ev_q <= (ev_q & ~wdata[2:0]) | ev_set;
         else
            ev_q <= ev_q | ev_set;
         if (wr && sel_mask)
            mask_q <= wdata[2:0];
         irq_q <= |(ev_q & mask_q);
      end
   end

   // Read data, registered, zero on unmapped addresses
   always @(posedge clk)
   begin
      if (por || rst)
      begin
         rdata_q <= `RDATA_RESET;
      end
      else if (ce)
      begin
         if (rd && sel_ctrl)
            rdata_q <= ctrl_word;                                      // RULE_15
         else if (rd && sel_stat)
            rdata_q <= {29'h0000_0000, ev_q};
         else if (rd && sel_mask)
            rdata_q <= {29'h0000_0000, mask_q};
         else
            rdata_q <= `RDATA_RESET;
      end
   end
endmodule

/* File: hw/flash_program_control_regs.vh */
// Register offsets, field positions and reset values of the flash control block
`ifndef FLASH_PROGRAM_CONTROL_REGS_VH
`define FLASH_PROGRAM_CONTROL_REGS_VH

// Register byte offsets
`define CTRL_OFS          8'h00
`define KEY_OFS           8'h04
`define IRQ_STATUS_OFS    8'h08
`define IRQ_MASK_OFS      8'h0C

// Control register field positions
`define START_BIT         15
`define ARM_BIT           14
`define FAIL_BIT          13
`define LS_ERR_BIT        12
`define LS_STAT_BIT       11
`define OP_MSB            3
`define OP_LSB            0

// Operation codes
`define OP_NONE           4'h0
`define OP_NOP_A          4'h2
`define OP_ROW_PROGRAM    4'h3
`define OP_PAGE_ERASE     4'h4
`define OP_FULL_ERASE     4'h5
`define OP_NOP_B          4'h6

// Flash array command encodings
`define CMD_ROW_PROGRAM   2'h1
`define CMD_PAGE_ERASE    2'h2
`define CMD_FULL_ERASE    2'h3

// Interrupt status bit positions
`define EV_DONE_BIT       0
`define EV_FAIL_BIT       1
`define EV_LOW_SUPPLY_BIT 2

// Reset values
`define OP_RESET          4'h0
`define IRQ_MASK_RESET    3'h0
`define RDATA_RESET       32'h0000_0000

`endif

/* File: hw/unlock_key_check.v */
// Two-word unlock key checker guarding the start bit
`timescale 1ns/1ps
module unlock_key_check
#(
   parameter [31:0] KEY_FIRST  = 32'h1234_ABCD, // Arbitrary key value
   parameter [31:0] KEY_SECOND = 32'hCDEF_5678  // Arbitrary key value
)
(
   clk,
   rst,
   ce,
   wr_stb,
   key_sel,
   wdata,
   unlocked_q
);
   input  wire        clk;
   input  wire        rst;
   input  wire        ce;
   input  wire        wr_stb;
   input  wire        key_sel;
   input  wire [31:0] wdata;
   output reg         unlocked_q;

   reg                half_q;

   // Key pair must be the last two writes; any other write drops the unlock
   always @(posedge clk)
   begin
      if (rst)
      begin
         half_q     <= 1'b0;
         unlocked_q <= 1'b0;
      end
      else if (ce && wr_stb)
      begin
         if (key_sel)
         begin
            half_q     <= (wdata == KEY_FIRST);                        // RULE_16
            unlocked_q <= half_q && (wdata == KEY_SECOND);             // RULE_16
         end
         else
         begin
            half_q     <= 1'b0;
            unlocked_q <= 1'b0;                                        // RULE_16
         end
      end
   end
endmodule

/* File: verification/flash_array_model.sv */
// Behavioural flash array answering each request after a set delay
`timescale 1ns/1ps
module flash_array_model
(
   input  wire logic       clk,
   input  wire logic       req,
   input  wire logic [1:0] cmd,
   input  wire logic       fail_en,
   input  int              dly,
   output logic            done,
   output logic            fail,
   output int              reqs,
   output logic [1:0]      last_cmd
);
   int         cnt    = 0;
   logic       done_q = 1'b0;
   logic       fail_q = 1'b1;
   int         reqs_q = 0;
   logic [1:0] cmd_q  = 2'h0;
   // Outputs come from the model's own state, one driver each
   assign done     = done_q;
   assign fail     = fail_q;
   assign reqs     = reqs_q;
   assign last_cmd = cmd_q;
   // Count requests, pulse done after the delay, fail toggles away from done
   always @(posedge clk)
   begin
      done_q <= 1'b0;
      fail_q <= ~fail_q;
      if (req)
      begin
         reqs_q <= reqs_q + 1;
         cmd_q  <= cmd;
         cnt    <= dly;
      end
      else if (cnt > 0)
         cnt <= cnt - 1;
      if (!req && cnt == 1)
      begin
         done_q <= 1'b1;
         fail_q <= fail_en;
      end
   end
endmodule

/* File: verification/flash_program_control_monitor.sv */
// Port-level checker of the flash control block
`timescale 1ns/1ps
`include "flash_program_control_regs.vh"
module flash_program_control_monitor
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        por,
   input wire logic        ce,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata_q,
   input wire logic        flash_done,
   input wire logic        flash_fail,
   input wire logic        protect_any,
   input wire logic        protect_target,
   input wire logic        low_supply_raw,
   input wire logic        flash_req_q,
   input wire logic [1:0]  flash_cmd_q,
   input wire logic        detector_en_q,
   input wire logic        busy_q,
   input wire logic        irq_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || por);
   // Request shape and its preconditions
   chk_req_pulse: assert property
      (flash_req_q |=> !flash_req_q) else $error("request longer than one cycle");
   chk_req_armed: assert property
      (flash_req_q |-> busy_q && detector_en_q) else $error("request while idle or unarmed");
   chk_busy_start: assert property
      ($rose(busy_q) |-> $past(wr) && $past(addr) == `CTRL_OFS && $past(wdata[`START_BIT]))
      else $error("busy without a start write");
   chk_done_ends: assert property
      ($rose(flash_done) && busy_q |-> ##[1:3] !busy_q) else $error("busy stuck after done");
   // Write protection guards
   chk_full_guard: assert property
      (flash_req_q && flash_cmd_q == `CMD_FULL_ERASE |-> !$past(protect_any))
      else $error("full erase while protected");
   chk_part_guard: assert property
      (flash_req_q && flash_cmd_q != `CMD_FULL_ERASE |-> !$past(protect_target))
      else $error("page or row op while protected");
   // Read data and reset
   chk_rdata_idle: assert property
      (!$past(rd) |-> rdata_q == 32'h0000_0000) else $error("read data outside slot");
   chk_reset_quiet: assert property
      ($fell(rst) |-> !busy_q && !flash_req_q && !detector_en_q) else $error("not quiet at reset");
endmodule
bind flash_program_control flash_program_control_monitor flash_program_control_monitor_i
(
   .clk(clk), .rst(rst), .por(por), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata_q(rdata_q), .flash_done(flash_done), .flash_fail(flash_fail),
   .protect_any(protect_any), .protect_target(protect_target),
   .low_supply_raw(low_supply_raw), .flash_req_q(flash_req_q), .flash_cmd_q(flash_cmd_q),
   .detector_en_q(detector_en_q), .busy_q(busy_q), .irq_q(irq_q)
);

/* File: verification/testbench.sv */
// Register-level bench of the flash control block
`timescale 1ns/1ps
`include "flash_program_control_regs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
   localparam [31:0] K1 = 32'h5A5A_0F0F; // Arbitrary key value
   localparam [31:0] K2 = 32'hA5A5_F0F0; // Arbitrary key value
   logic        clk = 0, rst = 1, por = 1, wr = 0, rd = 0, fail_en = 0, ce = 1;
   logic        protect_any = 0, protect_target = 0, low_supply_raw = 0;
   logic [7:0]  addr = 0;
   logic [31:0] wdata = 0, rdata_q;
   logic        flash_done, flash_fail, flash_req_q, detector_en_q, busy_q, irq_q;
   logic [1:0]  flash_cmd_q, last_cmd;
   int          mismatches = 0, checks_done = 0, reqs, nreq = 0, dly = 2;
   logic [3:0]  nop [3] = '{4'h2, 4'h6, 4'h0};
   logic [31:0] nexp [3] = '{32'h0000_7002, 32'h0000_7006, 32'h0000_4000};
   always #2.5 clk = ~clk;
   flash_program_control #(.KEY_FIRST(K1), .KEY_SECOND(K2)) flash_program_control_i
   (
      .clk(clk), .rst(rst), .por(por), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata_q(rdata_q), .flash_done(flash_done), .flash_fail(flash_fail),
      .protect_any(protect_any), .protect_target(protect_target),
      .low_supply_raw(low_supply_raw), .flash_req_q(flash_req_q), .flash_cmd_q(flash_cmd_q),
      .detector_en_q(detector_en_q), .busy_q(busy_q), .irq_q(irq_q)
   );
   flash_array_model flash_array_model_i
   (
      .clk(clk), .req(flash_req_q), .cmd(flash_cmd_q), .fail_en(fail_en), .dly(dly),
      .done(flash_done), .fail(flash_fail), .reqs(reqs), .last_cmd(last_cmd)
   );
   task automatic complete_run;
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 `CHK("rdata", e, rdata_q)
   endtask
   // Disarm, load the code, rearm, unlock, start, wait for idle
   task automatic start(input logic [3:0] op, input int n);
      int i;
      wreg(`CTRL_OFS, 32'h0000_0000);
      wreg(`CTRL_OFS, {28'h0, op});
      wreg(`CTRL_OFS, {16'h0, 4'h4, 8'h0, op});
      wreg(`KEY_OFS, K1);
      wreg(`KEY_OFS, K2);
      wreg(`CTRL_OFS, {16'h0, 4'hC, 8'h0, op});
      repeat (2) @(posedge clk);
      for (i = 0; i < 40 && busy_q !== 1'b0; i++) @(posedge clk);
      `CHK("busy", 1'b0, busy_q)
      nreq += n;
      `CHK("reqs", nreq, reqs)
   endtask
   initial
   begin
      #100000;
      mismatches++;
      complete_run();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 0;
      por <= 0;
      rreg(`CTRL_OFS, 32'h0000_0000);
      rreg(8'h10, 32'h0000_0000);
      wreg(`CTRL_OFS, 32'hFFFF_7FF3);
      rreg(`CTRL_OFS, 32'h0000_4003);
      wreg(`CTRL_OFS, 32'h0000_4005);
      rreg(`CTRL_OFS, 32'h0000_4003);
      wreg(`CTRL_OFS, 32'h0000_C003);
      rreg(`CTRL_OFS, 32'h0000_4003);
      wreg(`KEY_OFS, K1);
      wreg(`KEY_OFS, K2);
      wreg(`IRQ_MASK_OFS, 32'h0000_0007);
      wreg(`CTRL_OFS, 32'h0000_C003);
      rreg(`CTRL_OFS, 32'h0000_4003);
      start(4'h3, 1);
      `CHK("cmd", `CMD_ROW_PROGRAM, last_cmd)
      rreg(`CTRL_OFS, 32'h0000_4003);
      `CHK("irq", 1'b1, irq_q)
      rreg(`IRQ_STATUS_OFS, 32'h0000_0001);
      wreg(`IRQ_STATUS_OFS, 32'h0000_0001);
      rreg(`IRQ_STATUS_OFS, 32'h0000_0000);
      `CHK("irq", 1'b0, irq_q)
      fail_en <= 1;
      dly <= 9;
      start(4'h4, 1);
      `CHK("cmd", `CMD_PAGE_ERASE, last_cmd)
      rreg(`CTRL_OFS, 32'h0000_6004);
      rreg(`IRQ_STATUS_OFS, 32'h0000_0003);
      fail_en <= 0;
      protect_target <= 1;
      start(4'h3, 0);
      protect_target <= 0;
      protect_any <= 1;
      start(4'h5, 0);
      protect_any <= 0;
      start(4'h5, 1);
      `CHK("cmd", `CMD_FULL_ERASE, last_cmd)
      rst <= 1;
      @(posedge clk);
      rst <= 0;
      rreg(`CTRL_OFS, 32'h0000_2005);
      wreg(`CTRL_OFS, 32'h0000_4005);
      low_supply_raw <= 1;
      repeat (4) @(posedge clk);
      rreg(`CTRL_OFS, 32'h0000_7805);
      `CHK("det", 1'b1, detector_en_q)
      rreg(`IRQ_STATUS_OFS, 32'h0000_0004);
      low_supply_raw <= 0;
      repeat (4) @(posedge clk);
      rreg(`CTRL_OFS, 32'h0000_7005);
      for (int k = 0; k < 3; k++)
      begin
         start(nop[k], 0);
         rreg(`CTRL_OFS, nexp[k]);
      end
      wreg(`CTRL_OFS, 32'h0000_0000);
      low_supply_raw <= 1;
      repeat (4) @(posedge clk);
      rreg(`CTRL_OFS, 32'h0000_0000);
      `CHK("det", 1'b0, detector_en_q)
      // Clock enable low freezes a write to the control register
      @(posedge clk);
      ce <= 1'b0;
      wreg(`CTRL_OFS, 32'h0000_4003);
      ce <= 1'b1;
      rreg(`CTRL_OFS, 32'h0000_0000);
      `CHK("det", 1'b0, detector_en_q)
      complete_run();
   end
endmodule
